// ### hw/msd_defs.svh
// constants of the memory space decoder: data map, field positions, reset values
// assumes inclusion by bare name from the package and the design modules
`ifndef MSD_DEFS_SVH
`define MSD_DEFS_SVH

// ==========================================
// program space
`define MSD_PC_W         12
`define MSD_PROM_BYTES   4096
`define MSD_PROM_LAST    12'hfff
`define MSD_ERASED_BYTE  8'hff
`define MSD_REFUSED_BYTE 8'h00

// ==========================================
// stack space
`define MSD_STACK_DEPTH  6
`define MSD_DEPTH_W      3

// ==========================================
// data space map
`define MSD_RAM_BYTES    64
`define MSD_RAM_HI2      2'b00
`define MSD_WIN_HI2      2'b01
`define MSD_WIN_SEL_LSB  0
`define MSD_WIN_SEL_W    6
`define MSD_ADDR_X       8'h80
`define MSD_ADDR_Y       8'h81
`define MSD_ADDR_V       8'h82
`define MSD_ADDR_W       8'h83
`define MSD_ADDR_DR_A    8'hc0
`define MSD_ADDR_DR_B    8'hc1
`define MSD_ADDR_DR_C    8'hc2
`define MSD_ADDR_DDR_A   8'hc4
`define MSD_ADDR_DDR_B   8'hc5
`define MSD_ADDR_DDR_C   8'hc6
`define MSD_ADDR_IOR     8'hc8
`define MSD_ADDR_WINSEL  8'hc9
`define MSD_ADDR_OPT_A   8'hcc
`define MSD_ADDR_OPT_B   8'hcd
`define MSD_ADDR_OPT_C   8'hce
`define MSD_ADDR_PER_LO  8'hd0
`define MSD_ADDR_PER_HI  8'hfe
`define MSD_ADDR_ACC     8'hff

// ==========================================
// reset values
`define MSD_PORT_RST     24'h000000
`define MSD_REG_RST      8'h00
`define MSD_WIN_RST      6'h00

`endif

// ### hw/msd_pkg.sv
// types shared by the memory space decoder and its stack
// assumes msd_defs.svh is on the include path
`include "msd_defs.svh"

package msd_pkg;

  // ==========================================
  // programming port operations
  typedef enum logic [1:0] {
    msd_op_read    = 2'b00,
    msd_op_write   = 2'b01,
    msd_op_protect = 2'b10,
    msd_op_erase   = 2'b11
  } msd_op_t;

  typedef enum logic {
    msd_idle  = 1'b0,
    msd_erase = 1'b1
  } msd_mode_t;

  // ==========================================
  // stack state
  typedef struct packed {
    logic [`MSD_STACK_DEPTH-1:0][`MSD_PC_W-1:0] ent;
    logic [`MSD_DEPTH_W-1:0]                    depth;
    logic                                       overflow;
    logic                                       underflow;
  } msd_stack_state_t;

  // ==========================================
  // decoder state
  typedef struct packed {
    msd_mode_t                 mode;
    logic [`MSD_PC_W-1:0]      erase_addr;
    logic                      protect;
    logic                      prog_mode;
    logic                      nmi_prev;
    logic                      nmi_req;
    logic                      core_reset;
    logic [`MSD_WIN_SEL_W-1:0] win_sel;
    logic [7:0]                x;
    logic [7:0]                y;
    logic [7:0]                v;
    logic [7:0]                w;
    logic [7:0]                acc;
    logic [7:0]                ior;
    logic [23:0]               dr;
    logic [23:0]               ddr;
    logic [23:0]               opt;
    logic [23:0]               pull;
    logic [7:0]                fetch_data;
    logic                      fetch_valid;
    logic [7:0]                rdata;
    logic                      rvalid;
    logic [7:0]                ext_rdata;
    logic                      ext_rvalid;
    logic                      ext_refused;
    logic [`MSD_PC_W-1:0]      ret_addr;
    logic                      stack_overflow;
    logic                      periph_wr;
    logic [7:0]                periph_addr;
    logic [7:0]                periph_wdata;
  } msd_state_t;

endpackage

// ### hw/msd_stack_if.sv
// carrier between the decoder and its return address stack
// assumes one clock shared by both ends
`timescale 1ns/10ps
`default_nettype none
`include "msd_defs.svh"

interface msd_stack_if;
  logic                    push;
  logic                    pop;
  logic [`MSD_PC_W-1:0]    push_addr;
  logic [`MSD_PC_W-1:0]    top_addr;
  logic [`MSD_DEPTH_W-1:0] depth;
  logic                    overflow;
  logic                    underflow;

  modport core  (output push, pop, push_addr, input top_addr, depth, overflow, underflow);
  modport stack (input push, pop, push_addr, output top_addr, depth, overflow, underflow);
endinterface

`default_nettype wire

// ### hw/msd_stack.sv
// six-level return address stack, its own address space
// assumes push and pop come from the decoder, never both meant at once
`timescale 1ns/10ps
`default_nettype none
`include "msd_defs.svh"

module msd_stack (
  // clock and reset
  input  wire logic     clk_sys,
  input  wire logic     reset,
  // decoder side
  msd_stack_if.stack    sif
);

  msd_pkg::msd_stack_state_t st;
  msd_pkg::msd_stack_state_t next_st;

  // ==========================================
  // push and pop
  always_comb begin
    next_st = st;
    next_st.overflow = 1'b0;
    next_st.underflow = 1'b0;
    if (sif.push) begin
      if (st.depth == `MSD_DEPTH_W'(`MSD_STACK_DEPTH)) begin
        next_st.overflow = 1'b1;
      end else begin
        next_st.ent[st.depth] = sif.push_addr;
        next_st.depth = st.depth + `MSD_DEPTH_W'(1);
      end
    end else if (sif.pop) begin
      if (st.depth == '0) begin
        next_st.underflow = 1'b1;
      end else begin
        next_st.depth = st.depth - `MSD_DEPTH_W'(1);
      end
    end
    if (reset) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  // ==========================================
  // outputs
  assign sif.top_addr  = (st.depth == '0) ? '0 : st.ent[st.depth - `MSD_DEPTH_W'(1)];
  assign sif.depth     = st.depth;
  assign sif.overflow  = st.overflow;
  assign sif.underflow = st.underflow;

endmodule

`default_nettype wire

// ### hw/msd_space_decode.sv
// memory space decoder: program, data and stack spaces of a small 8-bit core
// assumes all inputs synchronous to clk_sys; program memory held here
`timescale 1ns/10ps
`default_nettype none
`include "msd_defs.svh"

module msd_space_decode (
  // clock and resets
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire logic                 reset_pin_n,
  // pins sensed
  input  wire logic                 nmi_pin_n,
  input  wire logic                 vpp_prog_level,
  // to the core
  output logic                      core_reset,
  output logic                      nmi_req,
  // instruction fetch
  input  wire logic                 core_fetch,
  input  wire logic [`MSD_PC_W-1:0] core_pc,
  output logic      [7:0]           fetch_data,
  output logic                      fetch_valid,
  // data space access
  input  wire logic                 core_rd,
  input  wire logic                 core_wr,
  input  wire logic [7:0]           core_addr,
  input  wire logic [7:0]           core_wdata,
  output logic      [7:0]           core_rdata,
  output logic                      core_rvalid,
  // stack space
  input  wire logic                 core_call,
  input  wire logic                 core_ret,
  input  wire logic [`MSD_PC_W-1:0] core_ret_from,
  output logic      [`MSD_PC_W-1:0] ret_addr,
  output logic                      stack_overflow,
  // external programming port
  input  wire logic                 ext_req,
  input  wire logic [1:0]           ext_op,
  input  wire logic [`MSD_PC_W-1:0] ext_addr,
  input  wire logic [7:0]           ext_wdata,
  output logic      [7:0]           ext_rdata,
  output logic                      ext_rvalid,
  output logic                      ext_refused,
  output logic                      ext_busy,
  output logic                      prog_mode,
  // peripheral registers
  input  wire logic [7:0]           periph_rdata,
  output logic                      periph_wr,
  output logic      [7:0]           periph_addr,
  output logic      [7:0]           periph_wdata,
  // port pins
  input  wire logic [23:0]          port_in,
  output logic      [23:0]          port_out,
  output logic      [23:0]          port_oe,
  output logic      [23:0]          pullup_input
);

  msd_pkg::msd_state_t st;
  msd_pkg::msd_state_t next_st;

  logic [7:0]           prom [`MSD_PROM_BYTES];
  logic [7:0]           ram  [`MSD_RAM_BYTES];
  logic                 rst_any;
  logic                 prom_we;
  logic [`MSD_PC_W-1:0] prom_wa;
  logic [7:0]           prom_wd;
  logic                 ram_we;
  logic                 ext_go;
  logic [`MSD_PC_W-1:0] win_addr;
  logic [23:0]          port_view;

  msd_stack_if sif ();

  msd_stack u_stack (
    .clk_sys (clk_sys),
    .reset   (rst_any),
    .sif     (sif)
  );

  // ==========================================
  // reset, window and port views
  assign rst_any   = reset | ~reset_pin_n;
  assign win_addr  = {st.win_sel, core_addr[5:0]};
  assign port_view = (st.ddr & st.dr) | (~st.ddr & port_in);
  assign ext_go    = ext_req & st.prog_mode & (st.mode == msd_pkg::msd_idle) & ~rst_any;

  // stack space has its own decode, apart from data addresses
  assign sif.push      = core_call & ~rst_any;
  assign sif.pop       = core_ret & ~core_call & ~rst_any;
  assign sif.push_addr = core_ret_from;

  // ==========================================
  // program memory writes
  always_comb begin
    prom_we = 1'b0;
    prom_wa = ext_addr;
    prom_wd = ext_wdata;
    if (st.mode == msd_pkg::msd_erase) begin
      prom_we = 1'b1;
      prom_wa = st.erase_addr;
      prom_wd = `MSD_ERASED_BYTE;
    end else if (ext_go && ext_op == msd_pkg::msd_op_write) begin
      prom_we = 1'b1;
    end
  end

  assign ram_we = core_wr & ~rst_any & (core_addr[7:6] == `MSD_RAM_HI2);

  always_ff @(posedge clk_sys) begin
    if (prom_we) begin
      prom[prom_wa] <= prom_wd;
    end
    if (ram_we) begin
      ram[core_addr[5:0]] <= core_wdata;
    end
  end

  // ==========================================
  // next state
  always_comb begin
    next_st = st;
    next_st.nmi_prev = nmi_pin_n;
    next_st.nmi_req = st.nmi_prev & ~nmi_pin_n & ~rst_any;
    next_st.core_reset = rst_any;
    next_st.fetch_valid = core_fetch;
    next_st.rvalid = core_rd;
    next_st.ext_rvalid = 1'b0;
    next_st.ext_refused = 1'b0;
    next_st.periph_wr = 1'b0;
    next_st.stack_overflow = sif.overflow;
    if (sif.pop) begin
      next_st.ret_addr = sif.top_addr;
    end

    // fetch through the 12-bit counter
    if (core_fetch) begin
      next_st.fetch_data = prom[core_pc];
    end

    // data space reads
    if (core_rd) begin
      next_st.rdata = 8'h00;
      if (core_addr[7:6] == `MSD_RAM_HI2) begin
        next_st.rdata = ram[core_addr[5:0]];
      end else if (core_addr[7:6] == `MSD_WIN_HI2) begin
        next_st.rdata = prom[win_addr];
      end else if (core_addr >= `MSD_ADDR_PER_LO && core_addr <= `MSD_ADDR_PER_HI) begin
        next_st.rdata = periph_rdata;
      end else begin
        case (core_addr)
          `MSD_ADDR_X:      next_st.rdata = st.x;
          `MSD_ADDR_Y:      next_st.rdata = st.y;
          `MSD_ADDR_V:      next_st.rdata = st.v;
          `MSD_ADDR_W:      next_st.rdata = st.w;
          `MSD_ADDR_ACC:    next_st.rdata = st.acc;
          `MSD_ADDR_DR_A:   next_st.rdata = port_view[7:0];
          `MSD_ADDR_DR_B:   next_st.rdata = port_view[15:8];
          `MSD_ADDR_DR_C:   next_st.rdata = port_view[23:16];
          `MSD_ADDR_DDR_A:  next_st.rdata = st.ddr[7:0];
          `MSD_ADDR_DDR_B:  next_st.rdata = st.ddr[15:8];
          `MSD_ADDR_DDR_C:  next_st.rdata = st.ddr[23:16];
          `MSD_ADDR_OPT_A:  next_st.rdata = st.opt[7:0];
          `MSD_ADDR_OPT_B:  next_st.rdata = st.opt[15:8];
          `MSD_ADDR_OPT_C:  next_st.rdata = st.opt[23:16];
          default:          next_st.rdata = 8'h00;
        endcase
      end
    end

    // data space writes
    if (core_wr) begin
      if (core_addr >= `MSD_ADDR_PER_LO && core_addr <= `MSD_ADDR_PER_HI) begin
        next_st.periph_wr = 1'b1;
        next_st.periph_addr = core_addr;
        next_st.periph_wdata = core_wdata;
      end
      case (core_addr)
        `MSD_ADDR_X:      next_st.x = core_wdata;
        `MSD_ADDR_Y:      next_st.y = core_wdata;
        `MSD_ADDR_V:      next_st.v = core_wdata;
        `MSD_ADDR_W:      next_st.w = core_wdata;
        `MSD_ADDR_ACC:    next_st.acc = core_wdata;
        `MSD_ADDR_IOR:    next_st.ior = core_wdata;
        `MSD_ADDR_WINSEL: next_st.win_sel = core_wdata[`MSD_WIN_SEL_W-1:0];
        `MSD_ADDR_DR_A:   next_st.dr[7:0] = core_wdata;
        `MSD_ADDR_DR_B:   next_st.dr[15:8] = core_wdata;
        `MSD_ADDR_DR_C:   next_st.dr[23:16] = core_wdata;
        `MSD_ADDR_DDR_A:  next_st.ddr[7:0] = core_wdata;
        `MSD_ADDR_DDR_B:  next_st.ddr[15:8] = core_wdata;
        `MSD_ADDR_DDR_C:  next_st.ddr[23:16] = core_wdata;
        `MSD_ADDR_OPT_A:  next_st.opt[7:0] = core_wdata;
        `MSD_ADDR_OPT_B:  next_st.opt[15:8] = core_wdata;
        `MSD_ADDR_OPT_C:  next_st.opt[23:16] = core_wdata;
        default:          next_st.acc = next_st.acc;
      endcase
    end

    // programming port and erase sweep
    case (st.mode)
      msd_pkg::msd_idle: begin
        if (ext_go) begin
          case (ext_op)
            msd_pkg::msd_op_read: begin
              next_st.ext_rvalid = 1'b1;
              next_st.ext_refused = st.protect;
              next_st.ext_rdata = st.protect ? `MSD_REFUSED_BYTE : prom[ext_addr];
            end
            msd_pkg::msd_op_protect: begin
              next_st.protect = 1'b1;
            end
            msd_pkg::msd_op_erase: begin
              next_st.mode = msd_pkg::msd_erase;
              next_st.erase_addr = '0;
            end
            default: begin
              next_st.protect = st.protect;
            end
          endcase
        end
      end
      msd_pkg::msd_erase: begin
        next_st.erase_addr = st.erase_addr + `MSD_PC_W'(1);
        if (st.erase_addr == `MSD_PROM_LAST) begin
          next_st.mode = msd_pkg::msd_idle;
          next_st.protect = 1'b0;
        end
      end
      default: begin
        next_st.mode = msd_pkg::msd_idle;
      end
    endcase

    next_st.pull = ~next_st.ddr & ~next_st.opt;

    // reset phase: latch programming level, restore pins and registers
    if (rst_any) begin
      next_st.prog_mode = vpp_prog_level;
      next_st.mode = msd_pkg::msd_idle;
      next_st.erase_addr = '0;
      next_st.fetch_valid = 1'b0;
      next_st.rvalid = 1'b0;
      next_st.ext_rvalid = 1'b0;
      next_st.ext_refused = 1'b0;
      next_st.periph_wr = 1'b0;
      next_st.stack_overflow = 1'b0;
      next_st.win_sel = `MSD_WIN_RST;
      next_st.ior = `MSD_REG_RST;
      next_st.dr = `MSD_PORT_RST;
      next_st.ddr = `MSD_PORT_RST;
      next_st.opt = `MSD_PORT_RST;
      next_st.pull = ~`MSD_PORT_RST;
    end
    if (reset) begin
      next_st.protect = 1'b0;
      next_st.fetch_data = 8'h00;
      next_st.rdata = 8'h00;
      next_st.ext_rdata = 8'h00;
      next_st.ret_addr = '0;
      next_st.periph_addr = 8'h00;
      next_st.periph_wdata = 8'h00;
      next_st.x = `MSD_REG_RST;
      next_st.y = `MSD_REG_RST;
      next_st.v = `MSD_REG_RST;
      next_st.w = `MSD_REG_RST;
      next_st.acc = `MSD_REG_RST;
    end
  end

  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  // ==========================================
  // outputs, each a flop of the state
  assign core_reset     = st.core_reset;
  assign nmi_req        = st.nmi_req;
  assign fetch_data     = st.fetch_data;
  assign fetch_valid    = st.fetch_valid;
  assign core_rdata     = st.rdata;
  assign core_rvalid    = st.rvalid;
  assign ret_addr       = st.ret_addr;
  assign stack_overflow = st.stack_overflow;
  assign ext_rdata      = st.ext_rdata;
  assign ext_rvalid     = st.ext_rvalid;
  assign ext_refused    = st.ext_refused;
  assign ext_busy       = st.mode;
  assign prog_mode      = st.prog_mode;
  assign periph_wr      = st.periph_wr;
  assign periph_addr    = st.periph_addr;
  assign periph_wdata   = st.periph_wdata;
  assign port_out       = st.dr;
  assign port_oe        = st.ddr;
  assign pullup_input   = st.pull;

endmodule

`default_nettype wire

// ### tb/msd_props.sv
// checker of the space decoder top ports
// assumes one clock domain, bound onto msd_space_decode
`timescale 1ns/10ps
`default_nettype none

module msd_props (
  // clock and resets
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        reset_pin_n,
  // pins and core side
  input wire logic        nmi_pin_n,
  input wire logic        nmi_req,
  input wire logic        core_reset,
  input wire logic        core_fetch,
  input wire logic        fetch_valid,
  input wire logic        core_rd,
  input wire logic        core_wr,
  input wire logic [7:0]  core_addr,
  input wire logic        core_rvalid,
  input wire logic        core_call,
  input wire logic        stack_overflow,
  input wire logic        periph_wr,
  input wire logic [7:0]  periph_addr,
  // programming port and pins
  input wire logic        ext_rvalid,
  input wire logic        ext_refused,
  input wire logic [7:0]  ext_rdata,
  input wire logic        ext_busy,
  input wire logic        prog_mode,
  input wire logic [23:0] port_oe,
  input wire logic [23:0] pullup_input
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  AST_NMI_EDGE: assert property ($fell(nmi_pin_n) && $past(reset_pin_n) && reset_pin_n
    && !core_reset |-> ##[1:2] (nmi_req || !reset_pin_n)) else $error("nmi fall lost");
  AST_NMI_ONCE: assert property (nmi_req |=> !nmi_req)
    else $error("nmi request too long");
  AST_NMI_RESET: assert property (!reset_pin_n |=> !nmi_req)
    else $error("nmi during reset");
  AST_RESET_PINS: assert property (!reset_pin_n |=> pullup_input == 24'hffffff
    && port_oe == 24'h000000) else $error("pins not pulled up inputs in reset");
  AST_PULL_OE: assert property ((pullup_input & port_oe) == 24'h000000)
    else $error("pull-up on driven pin");
  AST_FETCH: assert property (core_fetch && reset_pin_n && !core_reset |=> fetch_valid)
    else $error("fetch not answered");
  AST_READ: assert property (core_rd && reset_pin_n && !core_reset |=> core_rvalid)
    else $error("data read not answered");
  AST_PERIPH: assert property (core_wr && core_addr inside {[8'hd0:8'hfe]} && reset_pin_n
    && !core_reset |=> periph_wr && periph_addr == $past(core_addr)) else $error("periph write");
  AST_OVF: assert property (stack_overflow |-> $past(core_call, 2))
    else $error("overflow without call");
  AST_REFUSED: assert property (ext_refused |-> ext_rvalid && ext_rdata == 8'h00)
    else $error("refused read shows data");
  AST_BUSY: assert property (ext_busy |-> !ext_rvalid)
    else $error("read answered during erase");
  AST_PROG: assert property (!$past(reset) && reset_pin_n && $past(reset_pin_n)
    |-> $stable(prog_mode)) else $error("mode changed outside reset");
endmodule

bind msd_space_decode msd_props u_props (
  .clk_sys(clk_sys), .reset(reset), .reset_pin_n(reset_pin_n), .nmi_pin_n(nmi_pin_n),
  .nmi_req(nmi_req), .core_reset(core_reset), .core_fetch(core_fetch),
  .fetch_valid(fetch_valid), .core_rd(core_rd), .core_wr(core_wr), .core_addr(core_addr),
  .core_rvalid(core_rvalid), .core_call(core_call), .stack_overflow(stack_overflow),
  .periph_wr(periph_wr), .periph_addr(periph_addr), .ext_rvalid(ext_rvalid),
  .ext_refused(ext_refused), .ext_rdata(ext_rdata), .ext_busy(ext_busy),
  .prog_mode(prog_mode), .port_oe(port_oe), .pullup_input(pullup_input)
);

`default_nettype wire

// ### tb/msd_core_model.sv
// processor core model: fetch, data and stack requests
// assumes the bench calls one task at a time
`timescale 1ns/10ps
`default_nettype none

module msd_core_model (
  // clock
  input  wire logic        clk_sys,
  // requests
  output var  logic        core_fetch,
  output var  logic [11:0] core_pc,
  output var  logic        core_rd,
  output var  logic        core_wr,
  output var  logic [7:0]  core_addr,
  output var  logic [7:0]  core_wdata,
  output var  logic        core_call,
  output var  logic        core_ret,
  output var  logic [11:0] core_ret_from,
  // answers
  input  wire logic [7:0]  fetch_data,
  input  wire logic        fetch_valid,
  input  wire logic [7:0]  core_rdata,
  input  wire logic        core_rvalid,
  input  wire logic [11:0] ret_addr,
  input  wire logic        stack_overflow
);
  initial begin
    {core_fetch, core_rd, core_wr, core_call, core_ret} = 5'h00;
    {core_pc, core_ret_from, core_addr, core_wdata} = 40'h0;
  end

  task automatic fetch_op(input logic [11:0] pc, output logic [7:0] d, output logic v);
    @(negedge clk_sys);
    core_fetch = 1'b1;
    core_pc = pc;
    @(negedge clk_sys);
    core_fetch = 1'b0;
    d = fetch_data;
    v = fetch_valid;
    core_pc = ~pc;
  endtask

  task automatic data_op(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                         output logic [7:0] d, output logic v);
    @(negedge clk_sys);
    core_rd = !wr;
    core_wr = wr;
    core_addr = a;
    core_wdata = wd;
    @(negedge clk_sys);
    {core_rd, core_wr} = 2'b00;
    d = core_rdata;
    v = core_rvalid;
    core_addr = ~a;
    core_wdata = ~wd;
  endtask

  // pop answer one cycle after, overflow two cycles after
  task automatic stack_op(input logic call, input logic [11:0] from,
                          output logic [11:0] r, output logic o);
    @(negedge clk_sys);
    core_call = call;
    core_ret = !call;
    core_ret_from = from;
    @(negedge clk_sys);
    {core_call, core_ret} = 2'b00;
    r = ret_addr;
    core_ret_from = ~from;
    @(negedge clk_sys);
    o = stack_overflow;
  endtask
endmodule

`default_nettype wire

// ### tb/testbench.sv
// bench of the space decoder: window, stack, protection, pins
// assumes msd_core_model and msd_props compiled alongside
`timescale 1ns/10ps
`default_nettype none

module testbench;
  // ==========================================
  // signals
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        reset_pin_n = 1'b1;
  logic        nmi_pin_n = 1'b1;
  logic        vpp_prog_level = 1'b1;
  logic        ext_req = 1'b0;
  logic [1:0]  ext_op = 2'b00;
  logic [11:0] ext_addr = 12'h000;
  logic [7:0]  ext_wdata = 8'h00;
  logic        core_reset, nmi_req, core_fetch, fetch_valid, core_rd, core_wr, core_rvalid;
  logic        core_call, core_ret, stack_overflow, ext_rvalid, ext_refused, ext_busy;
  logic        prog_mode, periph_wr;
  logic [11:0] core_pc, core_ret_from, ret_addr;
  logic [7:0]  fetch_data, core_addr, core_wdata, core_rdata;
  logic [7:0]  ext_rdata, periph_addr, periph_wdata;
  logic [23:0] port_out, port_oe, pullup_input;
  int          n_mismatch = 0;
  int          checks_done = 0;

  always #5 clk_sys = ~clk_sys;

  msd_space_decode uut (
    .clk_sys(clk_sys), .reset(reset), .reset_pin_n(reset_pin_n), .nmi_pin_n(nmi_pin_n),
    .vpp_prog_level(vpp_prog_level), .core_reset(core_reset), .nmi_req(nmi_req),
    .core_fetch(core_fetch), .core_pc(core_pc), .fetch_data(fetch_data),
    .fetch_valid(fetch_valid), .core_rd(core_rd), .core_wr(core_wr), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_rdata(core_rdata), .core_rvalid(core_rvalid),
    .core_call(core_call), .core_ret(core_ret), .core_ret_from(core_ret_from),
    .ret_addr(ret_addr), .stack_overflow(stack_overflow), .ext_req(ext_req), .ext_op(ext_op),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
    .ext_rvalid(ext_rvalid), .ext_refused(ext_refused), .ext_busy(ext_busy),
    .prog_mode(prog_mode), .periph_rdata(8'h00), .periph_wr(periph_wr),
    .periph_addr(periph_addr), .periph_wdata(periph_wdata), .port_in(24'h000000),
    .port_out(port_out), .port_oe(port_oe), .pullup_input(pullup_input)
  );

  msd_core_model core (
    .clk_sys(clk_sys), .core_fetch(core_fetch), .core_pc(core_pc), .core_rd(core_rd),
    .core_wr(core_wr), .core_addr(core_addr), .core_wdata(core_wdata),
    .core_call(core_call), .core_ret(core_ret), .core_ret_from(core_ret_from),
    .fetch_data(fetch_data), .fetch_valid(fetch_valid), .core_rdata(core_rdata),
    .core_rvalid(core_rvalid), .ret_addr(ret_addr), .stack_overflow(stack_overflow)
  );

  // ==========================================
  // shared tasks
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic ext_cmd(input logic [1:0] op, input logic [11:0] a, input logic [7:0] wd,
                         output logic [8:0] ans);
    @(negedge clk_sys);
    ext_req = 1'b1;
    ext_op = op;
    ext_addr = a;
    ext_wdata = wd;
    @(negedge clk_sys);
    ext_req = 1'b0;
    ans = {ext_refused, ext_rdata};
  endtask

  // ==========================================
  // scenarios
  task automatic test_reset_state;
    check("prog_mode", {23'h0, prog_mode}, 24'h000001);
    check("pullup_input", pullup_input, 24'hffffff);
    check("port_oe", port_oe, 24'h000000);
    $display("test reset_state done");
  endtask

  task automatic test_window;
    logic [8:0] a;
    logic [7:0] d;
    logic       v;
    ext_cmd(2'b01, 12'h140, 8'h5a, a);
    ext_cmd(2'b01, 12'h17f, 8'ha7, a);
    ext_cmd(2'b01, 12'hfff, 8'h3c, a);
    // top select bits dropped, window writes ignored
    core.data_op(1'b1, 8'hc9, 8'hc5, d, v);
    core.data_op(1'b1, 8'h40, 8'h11, d, v);
    core.data_op(1'b0, 8'h40, 8'h00, d, v);
    check("window 40", {15'h0, v, d}, 24'h00015a);
    core.data_op(1'b0, 8'h7f, 8'h00, d, v);
    check("window 7f", {15'h0, v, d}, 24'h0001a7);
    core.fetch_op(12'hfff, d, v);
    check("fetch fff", {15'h0, v, d}, 24'h00013c);
    core.data_op(1'b1, 8'h3f, 8'h66, d, v);
    core.data_op(1'b0, 8'h3f, 8'h00, d, v);
    check("ram 3f", {15'h0, v, d}, 24'h000166);
    core.data_op(1'b1, 8'hd5, 8'h77, d, v);
    core.data_op(1'b1, 8'hc4, 8'h0f, d, v);
    repeat (2) @(negedge clk_sys);
    check("port_oe", port_oe, 24'h00000f);
    check("pullup_input", pullup_input, 24'hfffff0);
    $display("test window done");
  endtask

  task automatic test_stack;
    logic [11:0] r;
    logic        o;
    for (int i = 0; i < 7; i++) begin
      core.stack_op(1'b1, 12'h100 + 12'(i), r, o);
      check("overflow", {23'h0, o}, {23'h0, i == 6});
    end
    for (int i = 5; i >= 0; i--) begin
      core.stack_op(1'b0, 12'h000, r, o);
      check("ret_addr", {12'h0, r}, {12'h0, 12'h100 + 12'(i)});
    end
    $display("test stack done");
  endtask

  task automatic test_protect;
    logic [8:0] a;
    int         n;
    ext_cmd(2'b00, 12'h140, 8'h00, a);
    check("ext read", {15'h0, a}, 24'h00005a);
    ext_cmd(2'b10, 12'h000, 8'h00, a);
    ext_cmd(2'b00, 12'h140, 8'h00, a);
    check("ext protected", {15'h0, a}, 24'h000100);
    @(negedge clk_sys);
    reset_pin_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("pullup in pin reset", pullup_input, 24'hffffff);
    reset_pin_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    ext_cmd(2'b00, 12'h17f, 8'h00, a);
    check("kept protected", {15'h0, a}, 24'h000100);
    ext_cmd(2'b11, 12'h000, 8'h00, a);
    n = 0;
    while (ext_busy === 1'b1 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    check("erase cycles", 24'(n), 24'd4096);
    if (n >= 5000) begin
      print_verdict();
    end
    ext_cmd(2'b00, 12'h140, 8'h00, a);
    check("erased byte", {15'h0, a}, 24'h0000ff);
    $display("test protect done");
  endtask

  task automatic test_nmi;
    int p;
    p = 0;
    nmi_pin_n = 1'b0;
    repeat (6) begin
      @(negedge clk_sys);
      if (nmi_req === 1'b1) p++;
    end
    check("nmi pulses", 24'(p), 24'd1);
    nmi_pin_n = 1'b1;
    {reset_pin_n, vpp_prog_level} = 2'b00;
    repeat (2) @(negedge clk_sys);
    nmi_pin_n = 1'b0;
    p = 0;
    repeat (4) begin
      @(negedge clk_sys);
      if (nmi_req === 1'b1) p++;
    end
    check("nmi in reset", 24'(p), 24'd0);
    nmi_pin_n = 1'b1;
    @(negedge clk_sys);
    reset_pin_n = 1'b1;
    check("prog_mode", {23'h0, prog_mode}, 24'h0);
    $display("test nmi done");
  endtask

  initial begin
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    test_reset_state();
    test_window();
    test_stack();
    test_protect();
    test_nmi();
    print_verdict();
  end
endmodule

`default_nettype wire
